// ===== logic/cub_buffers.sv
`timescale 1ns/1ps

module cub_buffers
    import cub_pkg::*;
#(
    parameter int FRAMES = CUB_FRAMES,
    parameter int WORDS = CUB_WORDS,
    parameter int RESERVED = CUB_RESERVED
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Receiver frame stream
    input wire logic rx_frame,
    input wire logic rx_block_start,
    input wire logic rx_c_a,
    input wire logic rx_c_b,
    input wire logic rx_u_a,
    input wire logic rx_u_b,
    // Control port byte interface
    input wire logic cp_start,
    input wire logic [CUB_AW-1:0] cp_addr,
    input wire logic cp_wr,
    input wire logic [7:0] cp_wdata,
    input wire logic cp_rd,
    output logic [7:0] cp_rdata,
    output logic cp_rvalid,
    // Block copy interrupt
    output logic irq_copy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CUB_AW-1:0] ptr;
        logic phase;
        logic [7:0] irq_en;
        logic [7:0] buf_ctrl;
        logic [7:0] status;
        logic [7:0] rdata;
        logic rvalid;
        logic irq;
        logic [WORDS-1:0][15:0] cs_e;
        logic [WORDS-1:0][15:0] u_e;
    } cub_state_t;

    cub_state_t s;
    cub_state_t next_s;

    logic [WORDS-1:0][15:0] cs_d;
    logic [WORDS-1:0][15:0] u_d;
    logic block_done;
    logic locked;

    // ------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------
    function automatic logic in_cs(input logic [CUB_AW-1:0] a);
        in_cs = (a >= CUB_ADDR_CS_BASE) &&
                (a < CUB_ADDR_CS_BASE + 7'(WORDS)); // RULE_05
    endfunction

    function automatic logic in_u(input logic [CUB_AW-1:0] a);
        in_u = (a >= CUB_ADDR_U_BASE) &&
               (a < CUB_ADDR_U_BASE + 7'(WORDS));
    endfunction

    function automatic logic [4:0] word_of(
        input logic [CUB_AW-1:0] a,
        input logic [CUB_AW-1:0] base
    );
        logic [CUB_AW-1:0] off;
        off = a - base;
        word_of = off[4:0];
    endfunction

    // ------------------------------------------------------------
    // Capture side
    // ------------------------------------------------------------
    cub_capture #(
        .FRAMES(FRAMES),
        .WORDS(WORDS)
    ) u_capture (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .rx_frame(rx_frame),
        .rx_block_start(rx_block_start),
        .rx_c_a(rx_c_a),
        .rx_c_b(rx_c_b),
        .rx_u_a(rx_u_a),
        .rx_u_b(rx_u_b),
        .cs_d(cs_d),
        .u_d(u_d),
        .block_done(block_done),
        .locked(locked)
    ); // RULE_01 RULE_16

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic copy_cs;
        logic copy_u;
        logic skip_cs;
        logic skip_u;
        logic reserve;
        logic one_byte;
        logic chan_b;
        logic two_byte;
        logic [4:0] w;
        logic [7:0] rbyte;
        copy_cs = 1'b0;
        copy_u = 1'b0;
        skip_cs = 1'b0;
        skip_u = 1'b0;
        reserve = s.buf_ctrl[CUB_BC_RESERVE];
        one_byte = s.buf_ctrl[CUB_BC_ONE_BYTE];
        chan_b = s.buf_ctrl[CUB_BC_CHAN_B];
        two_byte = 1'b0;
        w = 5'h00;
        rbyte = 8'h00;
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.irq = 1'b0;

        // Block copies, whole block in one cycle.
        if (block_done) begin
            copy_cs = !s.buf_ctrl[CUB_BC_CS_INHIBIT]; // RULE_07 RULE_20
            copy_u = !s.buf_ctrl[CUB_BC_U_INHIBIT]; // RULE_07 RULE_20
            skip_cs = !copy_cs;
            skip_u = !copy_u;
        end
        for (int i = 0; i < WORDS; i++) begin
            // Reserved leading words keep what the host wrote there.
            if (copy_cs && !(reserve && i < RESERVED)) begin // RULE_09 RULE_10
                next_s.cs_e[i] = cs_d[i]; // RULE_03
            end
        end
        if (copy_u) begin
            next_s.u_e = u_d; // RULE_16
        end

        // Host access with auto-increment pointer.
        two_byte = in_u(s.ptr) || (in_cs(s.ptr) && !one_byte); // RULE_12 RULE_17
        if (cp_start) begin
            next_s.ptr = cp_addr;
            next_s.phase = 1'b0;
        end else if (cp_rd || cp_wr) begin
            if (in_cs(s.ptr)) begin
                w = word_of(s.ptr, CUB_ADDR_CS_BASE);
                if (two_byte) begin
                    rbyte = s.phase ? s.cs_e[w][7:0]
                                    : s.cs_e[w][15:8]; // RULE_15
                end else begin
                    rbyte = chan_b ? s.cs_e[w][7:0]
                                   : s.cs_e[w][15:8]; // RULE_13
                end
                if (cp_wr) begin
                    // A host write after a same-cycle copy wins.
                    if (two_byte ? s.phase : chan_b) begin
                        next_s.cs_e[w][7:0] = cp_wdata; // RULE_09
                    end else begin
                        next_s.cs_e[w][15:8] = cp_wdata; // RULE_09
                    end
                end
            end else if (in_u(s.ptr)) begin
                w = word_of(s.ptr, CUB_ADDR_U_BASE);
                rbyte = s.phase ? s.u_e[w][7:0]
                                : s.u_e[w][15:8]; // RULE_17 RULE_19
            end else begin
                case (s.ptr)
                    CUB_ADDR_IRQ_EN: begin
                        rbyte = s.irq_en;
                        if (cp_wr) begin
                            next_s.irq_en = cp_wdata & CUB_IRQ_EN_MASK;
                        end
                    end
                    CUB_ADDR_BUF_CTRL: begin
                        rbyte = s.buf_ctrl;
                        if (cp_wr) begin
                            next_s.buf_ctrl = cp_wdata & CUB_BUF_CTRL_MASK; // RULE_10
                        end
                    end
                    CUB_ADDR_STATUS: begin
                        rbyte = s.status;
                        if (cp_rd) begin
                            // Reading clears the sticky bits; a new
                            // event below sets them again.
                            next_s.status = s.status & ~CUB_STATUS_STICKY;
                        end
                    end
                    default: begin
                        rbyte = 8'h00;
                    end
                endcase
            end
            if (cp_rd) begin
                next_s.rdata = rbyte;
                next_s.rvalid = 1'b1;
            end
            if (two_byte && !s.phase) begin
                next_s.phase = 1'b1;
            end else begin
                next_s.phase = 1'b0;
                next_s.ptr = s.ptr + 7'h01; // RULE_14
            end
        end

        // Events: set wins over the read clear above.
        next_s.status[CUB_ST_LOCKED] = locked;
        if (copy_cs) begin
            next_s.status[CUB_ST_CS_COPIED] = 1'b1;
        end
        if (copy_u) begin
            next_s.status[CUB_ST_U_COPIED] = 1'b1;
        end
        if (skip_cs) begin
            next_s.status[CUB_ST_CS_SKIPPED] = 1'b1;
        end
        if (skip_u) begin
            next_s.status[CUB_ST_U_SKIPPED] = 1'b1;
        end
        // The pulse marks the start of the quiet window before the
        // next copy, in which the host can read without inhibit.
        next_s.irq = (copy_cs && s.irq_en[CUB_IE_CS_BIT]) ||
                     (copy_u && s.irq_en[CUB_IE_U_BIT]); // RULE_06 RULE_08
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.irq_en <= CUB_IRQ_EN_RST;
            s.buf_ctrl <= CUB_BUF_CTRL_RST;
            s.status <= CUB_STATUS_RST;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cp_rdata = s.rdata;
    assign cp_rvalid = s.rvalid;
    assign irq_copy = s.irq;

endmodule

// ===== logic/cub_pkg.sv
// What this block does
// (RULE_01) Store both CS blocks and one U block.
// (RULE_02) Receiver fills a hidden capture buffer.
// (RULE_03) Whole blocks copy into a host-readable buffer.
// (RULE_04) Byte MSB holds earliest received CS bit.
// (RULE_05) Readable CS buffer starts at address 20h.
// (RULE_06) Optional interrupt on every block copy.
// (RULE_07) Host inhibit bit suppresses block copies.
// (RULE_08) Host may read right after copy interrupt.
// (RULE_09) Reservation keeps first five bytes unchanged.
// (RULE_10) Buffer control register switches byte reservation.
// (RULE_11) 24 words, A upper byte, B lower.
// (RULE_12) Control bit picks one- or two-byte reads.
// (RULE_13) One-byte reads return A or B byte.
// (RULE_14) Reads follow control port address auto-increment.
// (RULE_15) Two-byte reads give A byte, then B.
// (RULE_16) User bits cascade through two buffers.
// (RULE_17) User buffer reads are always two-byte.
// (RULE_18) User word interleaves A and B bits.
// (RULE_19) User MSB first received, first byte first.
// (RULE_20) Copy only complete blocks while not inhibited.
package cub_pkg;

    // ------------------------------------------------------------
    // Block geometry
    // ------------------------------------------------------------
    localparam int CUB_FRAMES = 192;
    localparam int CUB_WORDS = 24;
    localparam int CUB_RESERVED = 5;
    localparam int CUB_AW = 7;

    // ------------------------------------------------------------
    // Control port address map
    // ------------------------------------------------------------
    localparam logic [6:0] CUB_ADDR_IRQ_EN = 7'h01;
    localparam logic [6:0] CUB_ADDR_BUF_CTRL = 7'h02;
    localparam logic [6:0] CUB_ADDR_STATUS = 7'h03;
    localparam logic [6:0] CUB_ADDR_CS_BASE = 7'h20;
    localparam logic [6:0] CUB_ADDR_U_BASE = 7'h38;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CUB_IE_CS_BIT = 0;
    localparam int CUB_IE_U_BIT = 1;
    localparam int CUB_BC_CS_INHIBIT = 0;
    localparam int CUB_BC_U_INHIBIT = 1;
    localparam int CUB_BC_RESERVE = 2;
    localparam int CUB_BC_ONE_BYTE = 3;
    localparam int CUB_BC_CHAN_B = 4;
    localparam int CUB_ST_CS_COPIED = 0;
    localparam int CUB_ST_U_COPIED = 1;
    localparam int CUB_ST_LOCKED = 2;
    localparam int CUB_ST_CS_SKIPPED = 3;
    localparam int CUB_ST_U_SKIPPED = 4;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] CUB_IRQ_EN_RST = 8'h00;
    localparam logic [7:0] CUB_BUF_CTRL_RST = 8'h00;
    localparam logic [7:0] CUB_STATUS_RST = 8'h00;
    localparam logic [7:0] CUB_IRQ_EN_MASK = 8'h03;
    localparam logic [7:0] CUB_BUF_CTRL_MASK = 8'h1f;
    localparam logic [7:0] CUB_STATUS_STICKY = 8'h1b;

endpackage

// ===== logic/cub_capture.sv
`timescale 1ns/1ps

module cub_capture
    import cub_pkg::*;
#(
    parameter int FRAMES = CUB_FRAMES,
    parameter int WORDS = CUB_WORDS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Receiver frame stream
    input wire logic rx_frame,
    input wire logic rx_block_start,
    input wire logic rx_c_a,
    input wire logic rx_c_b,
    input wire logic rx_u_a,
    input wire logic rx_u_b,
    // Capture buffer contents and events
    output logic [WORDS-1:0][15:0] cs_d,
    output logic [WORDS-1:0][15:0] u_d,
    output logic block_done,
    output logic locked
);

    typedef struct packed {
        logic locked;
        logic [7:0] idx;
        logic done;
        logic [WORDS-1:0][15:0] cs;
        logic [WORDS-1:0][15:0] u;
    } cub_cap_t;

    cub_cap_t s;
    cub_cap_t next_s;

    // ------------------------------------------------------------
    // Capture of one C bit pair and one U bit pair per frame
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] cur;
        logic [4:0] w;
        logic [2:0] bp;
        cur = 8'h00;
        w = 5'h00;
        bp = 3'h0;
        next_s = s;
        next_s.done = 1'b0;
        if (rx_frame) begin
            cur = rx_block_start ? 8'h00 : s.idx;
            w = cur[7:3];
            bp = 3'h7 - cur[2:0];
            if (rx_block_start) begin
                next_s.locked = 1'b1;
            end
            // Earliest bit lands in the byte MSB.
            next_s.cs[w][8 + bp] = rx_c_a; // RULE_02 RULE_04 RULE_11
            next_s.cs[w][bp] = rx_c_b; // RULE_02 RULE_04
            next_s.u[w][2 * bp + 1] = rx_u_a; // RULE_18 RULE_19
            next_s.u[w][2 * bp] = rx_u_b; // RULE_18
            if (cur == 8'(FRAMES - 1)) begin
                next_s.idx = 8'h00;
                // Any block ends whole once a start marker has been seen since reset.
                next_s.done = s.locked | rx_block_start; // RULE_20
            end else begin
                next_s.idx = cur + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cs_d = s.cs;
    assign u_d = s.u;
    assign block_done = s.done;
    assign locked = s.locked;

endmodule

// ===== testbench/cub_buffers_sva.sv
`timescale 1ns/1ps

module cub_buffers_chk
    import cub_pkg::*;
#(
    parameter int FRAMES = CUB_FRAMES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Receiver stream
    input wire logic rx_frame,
    input wire logic rx_block_start,
    input wire logic rx_c_a,
    input wire logic rx_c_b,
    input wire logic rx_u_a,
    input wire logic rx_u_b,
    // Control port
    input wire logic cp_start,
    input wire logic [CUB_AW-1:0] cp_addr,
    input wire logic cp_wr,
    input wire logic [7:0] cp_wdata,
    input wire logic cp_rd,
    input wire logic [7:0] cp_rdata,
    input wire logic cp_rvalid,
    input wire logic irq_copy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Frames since the last copy pulse; saturates so idle runs never wrap.
    logic [8:0] fcnt;
    logic seen_start;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fcnt <= '1;
            seen_start <= 1'b0;
        end else begin
            if (irq_copy)
                fcnt <= '0;
            else if (rx_frame && fcnt != '1)
                fcnt <= fcnt + 9'h001;
            if (rx_frame && rx_block_start)
                seen_start <= 1'b1;
        end
    end

    rvalid_after_rd_a: assert property (
        cp_rd && !cp_start |=> cp_rvalid) else $error("read not answered");
    rvalid_needs_rd_a: assert property (
        cp_rvalid |-> $past(cp_rd) && !$past(cp_start))
        else $error("stray read valid");
    rdata_holds_a: assert property (
        !cp_rvalid |-> $stable(cp_rdata)) else $error("read data moved");
    reset_clean_a: assert property (
        $rose(rstn) |-> cp_rdata == 8'h00 && !irq_copy)
        else $error("outputs not clear after reset");
    irq_pulse_a: assert property (
        irq_copy |=> !irq_copy) else $error("copy pulse too long");
    irq_after_frame_a: assert property (
        irq_copy |-> $past(rx_frame) || $past(rx_frame, 2))
        else $error("copy without a closing frame");
    irq_spacing_a: assert property (
        irq_copy |-> fcnt >= 9'(FRAMES - 2)) else $error("copy too early");
    irq_after_start_a: assert property (
        irq_copy |-> seen_start) else $error("copy before block start");

    cover property (irq_copy);
    cover property (cp_rd ##1 cp_rd ##1 cp_rd);
    cover property (cp_start ##1 cp_wr);
endmodule

bind cub_buffers cub_buffers_chk #(.FRAMES(FRAMES)) cub_buffers_chk_inst (
    .ref_clk(ref_clk), .rstn(rstn), .rx_frame(rx_frame),
    .rx_block_start(rx_block_start), .rx_c_a(rx_c_a), .rx_c_b(rx_c_b),
    .rx_u_a(rx_u_a), .rx_u_b(rx_u_b), .cp_start(cp_start),
    .cp_addr(cp_addr), .cp_wr(cp_wr), .cp_wdata(cp_wdata), .cp_rd(cp_rd),
    .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid), .irq_copy(irq_copy));

// ===== testbench/cub_host.sv
`timescale 1ns/1ps

module cub_host
    import cub_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Requests
    output logic cp_start,
    output logic [CUB_AW-1:0] cp_addr,
    output logic cp_wr,
    output logic [7:0] cp_wdata,
    output logic cp_rd,
    // Answers
    input wire logic [7:0] cp_rdata,
    input wire logic cp_rvalid
);
    logic [7:0] buf_q [0:63];
    int bad = 0;
    initial begin
        cp_start = 1'b0;
        cp_addr = '0;
        cp_wr = 1'b0;
        cp_wdata = 8'h00;
        cp_rd = 1'b0;
    end
    task automatic go(input logic [CUB_AW-1:0] a);
        cp_start = 1'b1;
        cp_addr = a;
        @(posedge ref_clk);
        #1;
        cp_start = 1'b0;
        cp_addr = ~a;
    endtask
    // Reads stay asserted back to back, one byte taken per edge.
    task automatic rd_n(input logic [CUB_AW-1:0] a, input int n);
        go(a);
        cp_rd = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            if (cp_rvalid !== 1'b1)
                bad++;
            buf_q[i] = cp_rdata;
        end
        cp_rd = 1'b0;
    endtask
    task automatic wr_n(input logic [CUB_AW-1:0] a, input int n);
        go(a);
        cp_wr = 1'b1;
        for (int i = 0; i < n; i++) begin
            cp_wdata = buf_q[i];
            @(posedge ref_clk);
            #1;
        end
        cp_wr = 1'b0;
        cp_wdata = ~cp_wdata;
    endtask
endmodule

// ===== testbench/cub_buffers_tb.sv
`timescale 1ns/1ps

module cub_buffers_tb
    import cub_pkg::*;
;
    logic ref_clk, rstn, rx_frame, rx_block_start;
    logic rx_c_a, rx_c_b, rx_u_a, rx_u_b;
    logic cp_start, cp_wr, cp_rd, cp_rvalid, irq_copy;
    logic [CUB_AW-1:0] cp_addr;
    logic [7:0] cp_wdata, cp_rdata, ie, bc;
    logic [31:0] seed = 32'ha91b3cbb;
    logic [7:0] ea [0:23], eb [0:23], ca [0:23], cb [0:23];
    logic [15:0] eu [0:23], cu [0:23];
    int failures = 0, checks = 0, cycles = 0, irqs = 0;

    cub_buffers cub_buffers_inst (.ref_clk(ref_clk), .rstn(rstn),
        .rx_frame(rx_frame), .rx_block_start(rx_block_start),
        .rx_c_a(rx_c_a), .rx_c_b(rx_c_b), .rx_u_a(rx_u_a), .rx_u_b(rx_u_b),
        .cp_start(cp_start), .cp_addr(cp_addr), .cp_wr(cp_wr),
        .cp_wdata(cp_wdata), .cp_rd(cp_rd), .cp_rdata(cp_rdata),
        .cp_rvalid(cp_rvalid), .irq_copy(irq_copy));
    cub_host cub_host_inst (.ref_clk(ref_clk), .cp_start(cp_start),
        .cp_addr(cp_addr), .cp_wr(cp_wr), .cp_wdata(cp_wdata),
        .cp_rd(cp_rd), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (irq_copy === 1'b1)
            irqs++;
        if (cycles > 10000) begin
            failures++;
            complete_run();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        cub_host_inst.buf_q[0] = d;
        cub_host_inst.wr_n(a, 1);
        if (a == CUB_ADDR_IRQ_EN)
            ie = d & CUB_IRQ_EN_MASK;
        if (a == CUB_ADDR_BUF_CTRL)
            bc = d & CUB_BUF_CTRL_MASK;
    endtask
    task automatic rd1(input logic [6:0] a, input logic [7:0] e, m,
                       input string nm);
        cub_host_inst.rd_n(a, 1);
        chk(nm, e, cub_host_inst.buf_q[0] & m);
    endtask
    // Two-byte reads of both areas; CS needs one-byte mode off.
    task automatic check_bufs();
        cub_host_inst.rd_n(CUB_ADDR_CS_BASE, 48);
        for (int i = 0; i < 24; i++) begin
            chk("cs a", ea[i], cub_host_inst.buf_q[2*i]);
            chk("cs b", eb[i], cub_host_inst.buf_q[2*i+1]);
        end
        cub_host_inst.rd_n(CUB_ADDR_U_BASE, 48);
        for (int i = 0; i < 24; i++) begin
            chk("u hi", eu[i][15:8], cub_host_inst.buf_q[2*i]);
            chk("u lo", eu[i][7:0], cub_host_inst.buf_q[2*i+1]);
        end
    endtask
    task automatic send_block();
        int n0;
        logic [31:0] r;
        n0 = irqs;
        for (int f = 0; f < CUB_FRAMES; f++) begin
            r = rnd();
            rx_frame = 1'b1;
            rx_block_start = (f == 0);
            {rx_c_a, rx_c_b, rx_u_a, rx_u_b} = r[3:0];
            ca[f/8][7-f%8] = r[3];
            cb[f/8][7-f%8] = r[2];
            cu[f/8][2*(7-f%8)+1] = r[1];
            cu[f/8][2*(7-f%8)] = r[0];
            @(posedge ref_clk);
            #1;
            rx_frame = 1'b0;
            {rx_block_start, rx_c_a, rx_c_b, rx_u_a, rx_u_b} = r[8:4];
            @(posedge ref_clk);
            #1;
        end
        repeat (2) @(posedge ref_clk);
        #1;
        for (int w = 0; w < CUB_WORDS; w++) begin
            if (!bc[CUB_BC_CS_INHIBIT] &&
                !(bc[CUB_BC_RESERVE] && w < CUB_RESERVED)) begin
                ea[w] = ca[w];
                eb[w] = cb[w];
            end
            if (!bc[CUB_BC_U_INHIBIT])
                eu[w] = cu[w];
        end
        chk("irq count", 8'((ie[0] && !bc[0]) || (ie[1] && !bc[1])),
            8'(irqs - n0));
    endtask

    initial begin
        rstn = 1'b0;
        {rx_frame, rx_block_start, rx_c_a, rx_c_b, rx_u_a, rx_u_b} = '0;
        ie = 8'h00;
        bc = 8'h00;
        for (int i = 0; i < 24; i++) begin
            ea[i] = 8'h00;
            eb[i] = 8'h00;
            eu[i] = 16'h0000;
        end
        repeat (4) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        cub_host_inst.rd_n(CUB_ADDR_IRQ_EN, 3);
        for (int i = 0; i < 3; i++)
            chk("reg reset", 8'h00, cub_host_inst.buf_q[i]);
        check_bufs();
        reg_wr(7'h7e, 8'h5a);
        rd1(7'h7e, 8'h00, 8'hff, "unmapped");
        reg_wr(CUB_ADDR_IRQ_EN, 8'h03);
        send_block();
        check_bufs();
        rd1(CUB_ADDR_STATUS, 8'h07, 8'hff, "status");
        rd1(CUB_ADDR_STATUS, 8'h00, 8'h1b, "status clear");
        for (int k = 0; k < 2; k++) begin
            reg_wr(CUB_ADDR_BUF_CTRL, k ? 8'h18 : 8'h08);
            cub_host_inst.rd_n(CUB_ADDR_CS_BASE, 24);
            for (int i = 0; i < 24; i++)
                chk("one byte", k ? eb[i] : ea[i],
                    cub_host_inst.buf_q[i]);
            cub_host_inst.rd_n(CUB_ADDR_U_BASE, 2);
            chk("u pair", eu[0][15:8], cub_host_inst.buf_q[0]);
            chk("u pair", eu[0][7:0], cub_host_inst.buf_q[1]);
        end
        reg_wr(CUB_ADDR_BUF_CTRL, 8'h04);
        rd1(CUB_ADDR_BUF_CTRL, 8'h04, 8'hff, "buf ctrl");
        for (int i = 0; i < 10; i++) begin
            cub_host_inst.buf_q[i] = 8'(rnd());
            if (i % 2 == 0)
                ea[i/2] = cub_host_inst.buf_q[i];
            else
                eb[i/2] = cub_host_inst.buf_q[i];
        end
        cub_host_inst.wr_n(CUB_ADDR_CS_BASE, 10);
        send_block();
        check_bufs();
        rd1(CUB_ADDR_STATUS, 8'h03, 8'h1b, "status");
        reg_wr(CUB_ADDR_BUF_CTRL, 8'h03);
        send_block();
        check_bufs();
        rd1(CUB_ADDR_STATUS, 8'h18, 8'h1b, "skipped");
        reg_wr(CUB_ADDR_IRQ_EN, 8'h00);
        reg_wr(CUB_ADDR_BUF_CTRL, 8'h00);
        send_block();
        check_bufs();
        chk("host reads", 8'h00, 8'(cub_host_inst.bad != 0));
        complete_run();
    end
endmodule
